// ==== rtl/period_timer.sv ====
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

module period_timer
	import period_timer_pkg::*;
(
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire period_timer_pkg::apb_req_t APB_REQ_IN,
	output period_timer_pkg::apb_rsp_t APB_RSP_OUT,
	output logic IRQ_OUT,
	output logic PWM_TIMEBASE_OUT
);
	import period_timer_pkg::*;

	typedef struct packed {
		apb_phase_t phase;
		logic [1:0] qdiv;
		logic [7:0] count;
		logic [6:0] control;
		logic [7:0] period;
		logic [3:0] post;
		logic flag;
		logic enable;
		apb_rsp_t rsp;
		logic irq;
		logic tb;
	} timer_state_t;

	timer_state_t st;
	timer_state_t next_st;
	logic tick;
	logic advance;
	logic match;
	logic wr_count;
	logic wr_control;
	logic do_write;
	logic do_read;
	logic mapped;
	logic [7:0] rdata;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// The slave answers in the first access cycle: pready is raised in
	// the setup cycle's successor, so every transfer is zero-wait.
	always_comb begin
		mapped = 1'b1;
		rdata = 8'h00;
		case (APB_REQ_IN.paddr)
			ADDR_TIMER_COUNT: rdata = st.count;
			ADDR_TIMER_CONTROL: rdata = {1'b0, st.control};
			ADDR_PERIOD_VALUE: rdata = st.period;
			ADDR_INT_STATUS: rdata = 8'(st.flag) << FLAG_MATCH_BIT;
			ADDR_INT_ENABLE: rdata = 8'(st.enable) << FLAG_MATCH_BIT;
			default: mapped = 1'b0;
		endcase
	end

	// A write lands at the edge where the master samples pready high,
	// so the register changes exactly when the transfer completes.
	assign do_write = APB_REQ_IN.psel && APB_REQ_IN.penable
		&& APB_REQ_IN.pwrite && mapped && st.rsp.pready;
	assign do_read = APB_REQ_IN.psel && !APB_REQ_IN.penable
		&& !APB_REQ_IN.pwrite;
	assign wr_count = do_write && APB_REQ_IN.paddr == ADDR_TIMER_COUNT;
	assign wr_control = do_write
		&& APB_REQ_IN.paddr == ADDR_TIMER_CONTROL;

	// ----------------------------------------------------------------
	// Instruction clock and prescaler
	// ----------------------------------------------------------------
	// One tick every fourth master clock models oscillator/4.
	assign tick = st.control[CTL_RUN_BIT] && st.qdiv == CLK_DIV;

	period_scaler u_prescale (
		.clk(MCLK_IN),
		.rst(RST_IN),
		.clear_in(wr_count || wr_control),
		.tick_in(tick),
		.select_in(st.control[CTL_PRESCALE_LSB +: 2]),
		.advance_out(advance)
	);

	// Comparison only counts when the count really advances.
	assign match = advance && st.count == st.period;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Writes are committed in the access cycle, at the edge that
	// completes the transfer; read data was latched one edge earlier
	// so that it stands while pready is high.
	always_comb begin
		next_st = st;
		next_st.qdiv = st.qdiv + 2'h1;
		next_st.tb = match;
		// Count advance and wrap.
		if (advance) begin
			next_st.count = match ? 8'h00 : st.count + 8'h01;
		end
		// Postscaler: field value plus one matches per flag.
		if (match) begin
			if (st.post >= st.control[CTL_POSTSCALE_LSB +: 4]) begin
				next_st.post = 4'h0;
			end else begin
				next_st.post = st.post + 4'h1;
			end
		end
		if (wr_count || wr_control) begin
			next_st.post = 4'h0;
		end
		// Register writes.
		if (wr_count) begin
			next_st.count = APB_REQ_IN.pwdata[7:0];
		end
		if (wr_control) begin
			// Count untouched by a control write.
			next_st.control = APB_REQ_IN.pwdata[6:0];
		end
		if (do_write && APB_REQ_IN.paddr == ADDR_PERIOD_VALUE) begin
			next_st.period = APB_REQ_IN.pwdata[7:0];
		end
		if (do_write && APB_REQ_IN.paddr == ADDR_INT_ENABLE) begin
			next_st.enable = APB_REQ_IN.pwdata[FLAG_MATCH_BIT];
		end
		if (do_write && APB_REQ_IN.paddr == ADDR_INT_STATUS
			&& APB_REQ_IN.pwdata[FLAG_MATCH_BIT]) begin
			next_st.flag = 1'b0;
		end
		// Setting wins over a clear in the same cycle.
		if (match && st.post >= st.control[CTL_POSTSCALE_LSB +: 4]) begin
			next_st.flag = 1'b1;
		end
		next_st.irq = next_st.flag && next_st.enable;
		// Bus response.
		next_st.rsp.pready = 1'b0;
		next_st.rsp.pslverr = 1'b0;
		next_st.rsp.prdata = 32'h0;
		case (st.phase)
			PH_SETUP: begin
				if (APB_REQ_IN.psel && !APB_REQ_IN.penable) begin
					next_st.phase = PH_ACCESS;
					next_st.rsp.pready = 1'b1;
					next_st.rsp.pslverr = !mapped;
					if (do_read) begin
						next_st.rsp.prdata = {24'h0, rdata};
					end
				end
			end
			PH_ACCESS: begin
				next_st.phase = PH_SETUP;
				if (APB_REQ_IN.psel && !APB_REQ_IN.penable) begin
					next_st.phase = PH_ACCESS;
					next_st.rsp.pready = 1'b1;
					next_st.rsp.pslverr = !mapped;
					if (do_read) begin
						next_st.rsp.prdata = {24'h0, rdata};
					end
				end
			end
			default: next_st.phase = PH_SETUP;
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset stands for every device reset source.
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			st <= '0;
			st.phase <= PH_SETUP;
			st.count <= RST_TIMER_COUNT;
			st.control <= RST_TIMER_CONTROL;
			st.period <= RST_PERIOD_VALUE;
		end else begin
			st <= next_st;
		end
	end

	assign APB_RSP_OUT = st.rsp;
	assign IRQ_OUT = st.irq;
	assign PWM_TIMEBASE_OUT = st.tb;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_run_gate;
		@(posedge MCLK_IN) disable iff (RST_IN)
		!st.control[CTL_RUN_BIT] && !wr_count |=> $stable(st.count);
	endproperty
	a_run_gate: assert property (p_run_gate)
		else $error("Count moved while stopped.");

	property p_wrap;
		@(posedge MCLK_IN) disable iff (RST_IN)
		match && !wr_count |=> st.count == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("Count did not wrap after match.");

	property p_tick_spacing;
		@(posedge MCLK_IN) disable iff (RST_IN)
		tick |=> !tick [*3];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("Instruction tick faster than one in four.");

	property p_no_repeat;
		@(posedge MCLK_IN) disable iff (RST_IN)
		!advance |=> !PWM_TIMEBASE_OUT;
	endproperty
	a_no_repeat: assert property (p_no_repeat)
		else $error("Match without a counter advance.");

	property p_ctl_keeps_count;
		@(posedge MCLK_IN) disable iff (RST_IN)
		wr_control && !advance |=> st.count == $past(st.count);
	endproperty
	a_ctl_keeps_count: assert property (p_ctl_keeps_count)
		else $error("Control write changed the count.");

	property p_scaler_clear;
		@(posedge MCLK_IN) disable iff (RST_IN)
		wr_count || wr_control |=> st.post == 4'h0;
	endproperty
	a_scaler_clear: assert property (p_scaler_clear)
		else $error("Postscaler not cleared by write.");

	property p_flag_set;
		@(posedge MCLK_IN) disable iff (RST_IN)
		match && st.post >= st.control[CTL_POSTSCALE_LSB +: 4]
		|=> st.flag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("Completed postscale did not set the flag.");

	property p_bit7_zero;
		@(posedge MCLK_IN) disable iff (RST_IN)
		do_read && APB_REQ_IN.paddr == ADDR_TIMER_CONTROL
		|=> APB_RSP_OUT.prdata[7] == 1'b0;
	endproperty
	a_bit7_zero: assert property (p_bit7_zero)
		else $error("Control bit 7 read as one.");

	property p_irq;
		@(posedge MCLK_IN) disable iff (RST_IN)
		st.flag && st.enable |-> IRQ_OUT || $past(RST_IN);
	endproperty
	a_irq: assert property (p_irq)
		else $error("Interrupt missing while flag enabled.");

	property p_timebase;
		@(posedge MCLK_IN) disable iff (RST_IN)
		match |=> PWM_TIMEBASE_OUT ##1 !PWM_TIMEBASE_OUT;
	endproperty
	a_timebase: assert property (p_timebase)
		else $error("Time base pulse not one cycle after match.");

	property p_count_write;
		@(posedge MCLK_IN) disable iff (RST_IN)
		wr_count |=> st.count == $past(APB_REQ_IN.pwdata[7:0]);
	endproperty
	a_count_write: assert property (p_count_write)
		else $error("Count write did not land.");

	property p_period_write;
		@(posedge MCLK_IN) disable iff (RST_IN)
		do_write && APB_REQ_IN.paddr == ADDR_PERIOD_VALUE
		|=> st.period == $past(APB_REQ_IN.pwdata[7:0]);
	endproperty
	a_period_write: assert property (p_period_write)
		else $error("Period write did not land.");

	property p_post_step;
		@(posedge MCLK_IN) disable iff (RST_IN)
		match && st.post < st.control[CTL_POSTSCALE_LSB +: 4]
		&& !wr_count && !wr_control
		|=> st.post == $past(st.post) + 4'h1;
	endproperty
	a_post_step: assert property (p_post_step)
		else $error("Postscaler did not step on a match.");

	property p_flag_sticky;
		@(posedge MCLK_IN) disable iff (RST_IN)
		st.flag && !(do_write && APB_REQ_IN.paddr == ADDR_INT_STATUS
		&& APB_REQ_IN.pwdata[FLAG_MATCH_BIT]) |=> st.flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("Match flag dropped without a clear.");

	property p_irq_low;
		@(posedge MCLK_IN) disable iff (RST_IN)
		!(st.flag && st.enable) |-> !IRQ_OUT;
	endproperty
	a_irq_low: assert property (p_irq_low)
		else $error("Interrupt raised without an enabled flag.");
endmodule

// ==== common/period_timer_pkg.sv ====
package period_timer_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	// Printed offsets are not all multiples of four, so they are word
	// indices and the byte address is four times the index.
	localparam logic [7:0] IDX_TIMER_COUNT = 8'h11;
	localparam logic [7:0] IDX_TIMER_CONTROL = 8'h12;
	localparam logic [7:0] IDX_PERIOD_VALUE = 8'h92;
	localparam logic [7:0] IDX_INT_STATUS = 8'h0c;
	localparam logic [7:0] IDX_INT_ENABLE = 8'h8c;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_COUNT = 12'h044;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_CONTROL = 12'h048;
	localparam logic [ADDR_W-1:0] ADDR_PERIOD_VALUE = 12'h248;
	localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 12'h030;
	localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 12'h230;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int CTL_PRESCALE_LSB = 0;
	localparam int CTL_RUN_BIT = 2;
	localparam int CTL_POSTSCALE_LSB = 3;
	localparam int FLAG_MATCH_BIT = 1;
	localparam logic [7:0] CONTROL_WMASK = 8'h7f;
	localparam logic [7:0] RST_TIMER_COUNT = 8'h00;
	localparam logic [6:0] RST_TIMER_CONTROL = 7'h00;
	localparam logic [7:0] RST_PERIOD_VALUE = 8'hff;
	localparam logic [1:0] CLK_DIV = 2'h3;

	// Prescale codes.
	localparam logic [1:0] PRE_DIV1 = 2'h0;
	localparam logic [1:0] PRE_DIV4 = 2'h1;
	localparam logic [3:0] PRE_LAST4 = 4'h3;
	localparam logic [3:0] PRE_LAST16 = 4'hf;

	typedef enum logic {PH_SETUP, PH_ACCESS} apb_phase_t;

	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

endpackage

// ==== rtl/period_scaler.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Prescaler: turns instruction-clock ticks into count advances.
// ----------------------------------------------------------------
module period_scaler
	import period_timer_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clear_in,
	input wire logic tick_in,
	input wire logic [1:0] select_in,
	output logic advance_out
);
	typedef struct packed {
		logic [3:0] cnt;
	} scaler_state_t;

	scaler_state_t st;
	scaler_state_t next_st;
	logic [3:0] last;

	// The terminal count follows the select code; 1x means sixteen.
	always_comb begin
		next_st = st;
		if (select_in == PRE_DIV1) begin
			last = 4'h0;
		end else if (select_in == PRE_DIV4) begin
			last = PRE_LAST4;
		end else begin
			last = PRE_LAST16;
		end
		advance_out = tick_in && (st.cnt >= last);
		if (clear_in) begin
			next_st.cnt = 4'h0;
		end else if (tick_in) begin
			next_st.cnt = advance_out ? 4'h0 : st.cnt + 4'h1;
		end
	end

	// Stale counts above a new, shorter limit wrap at once via >=.
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// ==== dv/period_timer_test.sv ====
`timescale 1ns/1ps

module period_timer_test;
	import period_timer_pkg::*;

	// ----------------------------------------------------------------
	// Bench state
	// ----------------------------------------------------------------
	logic mclk = 1'b0;
	logic rst = 1'b1;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic irq;
	logic timebase;
	int num_errors = 0;
	int total_checks = 0;
	int cycle = 0;
	int last_pulse = 0;
	logic [31:0] seed = 32'd860;
	logic [10:0] note;
	logic [10:0] read_notes[$];
	int gap_notes[$];
	logic [7:0] per;
	logic [7:0] val;
	logic [3:0] ps;

	// The clock toggles every half period of 2.5 ns.
	always #2.5 mclk = ~mclk;

	period_timer u_dut (
		.MCLK_IN(mclk),
		.RST_IN(rst),
		.APB_REQ_IN(req),
		.APB_RSP_OUT(rsp),
		.IRQ_OUT(irq),
		.PWM_TIMEBASE_OUT(timebase)
	);

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic check(input string name, input logic [15:0] exp,
			input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic complete_run();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Bus and event helpers
	// ----------------------------------------------------------------
	// One whole transfer; a spare edge at the end keeps back-to-back
	// calls from assigning the strobes twice in one time step.
	task automatic apb(input logic [11:0] a, input logic w,
			input logic [7:0] d);
		req.paddr <= a;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.pwdata <= {24'h0, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		// No cycle limit here: a slave that never answers is caught by
		// the watchdog, which ends the run as a failure.
		do begin
			@(posedge mclk);
		end while (rsp.pready !== 1'b1);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge mclk);
	endtask

	// Flags are {check interrupt, interrupt level, slave error}.
	task automatic rd(input logic [11:0] a, input logic [7:0] exp,
			input logic [2:0] flags);
		read_notes.push_back({flags, exp});
		apb(a, 1'b0, 8'h00);
	endtask

	task automatic wait_pulse();
		do begin
			@(posedge mclk);
		end while (timebase !== 1'b1);
	endtask

	// Spacing of time-base pulses: four clocks per instruction tick.
	task automatic gap_test(input logic [1:0] pre, input int div);
		apb(ADDR_TIMER_COUNT, 1'b1, 8'h00);
		apb(ADDR_PERIOD_VALUE, 1'b1, per);
		apb(ADDR_TIMER_CONTROL, 1'b1, {5'h00, 1'b1, pre});
		repeat (2) begin
			wait_pulse();
			#1 gap_notes.push_back(4 * div * (per + 1));
		end
		wait_pulse();
		apb(ADDR_TIMER_CONTROL, 1'b1, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// Monitor: pairs each read answer with the oldest note
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		cycle <= cycle + 1;
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1
				&& read_notes.size() > 0) begin
			note = read_notes.pop_front();
			check("read data", {8'h0, note[7:0]}, rsp.prdata[15:0]);
			check("slave error", {15'h0, note[8]}, {15'h0, rsp.pslverr});
			if (note[10]) begin
				check("interrupt", {15'h0, note[9]}, {15'h0, irq});
			end
		end
		if (timebase === 1'b1) begin
			if (gap_notes.size() > 0) begin
				check("pulse gap", 16'(gap_notes.pop_front()),
					16'(cycle - last_pulse));
			end
			last_pulse <= cycle;
		end
	end

	// Worst case is a few thousand cycles; the limit leaves wide margin.
	initial begin
		#(60000 * 5);
		num_errors++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(ADDR_TIMER_COUNT, 8'h00, 3'b000);
		rd(ADDR_TIMER_CONTROL, 8'h00, 3'b000);
		rd(ADDR_PERIOD_VALUE, 8'hff, 3'b000);
		rd(ADDR_INT_STATUS, 8'h00, 3'b100);
		rd(ADDR_INT_ENABLE, 8'h00, 3'b000);
		apb(ADDR_TIMER_CONTROL, 1'b1, 8'hfb);
		rd(ADDR_TIMER_CONTROL, 8'h7b, 3'b000);
		seed = xorshift(seed);
		apb(ADDR_PERIOD_VALUE, 1'b1, seed[7:0]);
		rd(ADDR_PERIOD_VALUE, seed[7:0], 3'b000);
		seed = xorshift(seed);
		val = seed[7:0];
		apb(ADDR_TIMER_COUNT, 1'b1, val);
		apb(ADDR_TIMER_CONTROL, 1'b1, 8'h03);
		rd(ADDR_TIMER_COUNT, val, 3'b000);
		repeat (50) @(posedge mclk);
		rd(ADDR_TIMER_COUNT, val, 3'b000);
		rd(12'h100, 8'h00, 3'b001);
		// Every prescale code, including both upper codes.
		for (int c = 0; c < 4; c++) begin
			seed = xorshift(seed);
			per = {6'h0, seed[1:0]};
			gap_test(c[1:0], c == 0 ? 1 : (c == 1 ? 4 : 16));
		end
		// Postscale at both ends and in between; control writes clear it.
		per = 8'h03;
		apb(ADDR_PERIOD_VALUE, 1'b1, per);
		for (int i = 0; i < 3; i++) begin
			ps = 4'(i * 7 + i / 2);
			apb(ADDR_TIMER_CONTROL, 1'b1, {1'b0, ps, 3'b000});
			apb(ADDR_TIMER_COUNT, 1'b1, 8'h00);
			apb(ADDR_INT_STATUS, 1'b1, 8'h02);
			apb(ADDR_INT_ENABLE, 1'b1, 8'h02);
			apb(ADDR_TIMER_CONTROL, 1'b1, {1'b0, ps, 3'b100});
			repeat (ps) wait_pulse();
			rd(ADDR_INT_STATUS, 8'h00, 3'b100);
			wait_pulse();
			repeat (3) @(posedge mclk);
			rd(ADDR_INT_STATUS, 8'h02, 3'b110);
			apb(ADDR_TIMER_CONTROL, 1'b1, 8'h00);
			apb(ADDR_INT_ENABLE, 1'b1, 8'h00);
			rd(ADDR_INT_STATUS, 8'h02, 3'b100);
			apb(ADDR_INT_STATUS, 1'b1, 8'h02);
			rd(ADDR_INT_STATUS, 8'h00, 3'b100);
		end
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(ADDR_PERIOD_VALUE, 8'hff, 3'b000);
		rd(ADDR_TIMER_COUNT, 8'h00, 3'b000);
		repeat (5) @(posedge mclk);
		check("notes left", 16'h0, 16'(read_notes.size() + gap_notes.size()));
		complete_run();
	end
endmodule
